// file: hw/efs_pkg.sv
// package for the e1 framer sync and overhead block
package efs_pkg;

  // apb register byte offsets
  localparam logic [7:0] A_FRAMER  = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IMASK   = 8'h08;
  localparam logic [7:0] A_EVENTS  = 8'h0c;
  localparam logic [7:0] A_HDLC1   = 8'h10;
  localparam logic [7:0] A_HDLC2   = 8'h14;
  localparam logic [7:0] A_HDLC3   = 8'h18;
  localparam logic [7:0] A_SLOTS   = 8'h1c;
  localparam logic [7:0] A_COMMAND = 8'h20;
  localparam logic [7:0] A_TXSIG   = 8'h40;
  localparam logic [7:0] A_RXSIG   = 8'h80;
  localparam logic [7:0] A_SIG_END = 8'hc0;

  // framer control bit positions
  localparam int B_AUTO_EBIT  = 0;
  localparam int B_EBIT_POL   = 1;
  localparam int B_AUTO_RAI   = 2;
  localparam int B_FRS_LO     = 3;
  localparam int B_AUTO_RESYN = 5;
  localparam int B_CRC_RESYN  = 6;
  localparam int B_EXT_IW     = 7;
  localparam int B_CAS_EN     = 8;
  localparam int B_SIG_OPT    = 9;
  localparam int B_LINE_STD   = 10;

  localparam logic [1:0] FRS_CRC4 = 2'b10;
  localparam logic [1:0] FRS_IW   = 2'b11;

  // event bit positions
  localparam int E_IW400 = 0;
  localparam int E_CAS_CHANGE_EVENT  = 1;
  localparam int E_HDLC  = 2;
  localparam int NEV     = 11;

  // reset values
  localparam logic [10:0] FRAMER_RST = 11'h000;
  localparam logic [10:0] IMASK_RST  = 11'h7ff;
  localparam logic [7:0]  MODE_RST   = 8'h00;

  // timing
  localparam int CLK_HZ      = 40000000;
  localparam int T_MF_MS     = 8;
  localparam int T_IW_MS     = 400;
  localparam int T_CRC_MS    = 1000;
  localparam int CRC_LIMIT   = 914;
  localparam int CYC_PER_MS  = CLK_HZ / 1000;
  localparam logic [15:0] MS_TICK = 16'(CYC_PER_MS - 1);

  typedef enum logic [1:0] {
    SY_ASYNC,
    SY_BASIC,
    SY_MULTI
  } efs_sync_t;

  typedef struct packed {
    logic        frame_ok;
    logic        mf_found;
    logic        crc_err;
    logic        mf_start;
    logic        smf_crc_ok;
    logic [1:0]  receive_message_end;
    logic [2:0]  hdlc_ev;
  } efs_line_in_t;

endpackage : efs_pkg

// file: hw/efs_core.sv
// e1 framer synchronization control and time slot 0/16 overhead setup
//
// Functional notes
// R1 - auto e-bit on: send received submultiframe crc status as next multiframe's e-bits
// R2 - in asynchronous state send e-bit equal to polarity control
// R3 - auto remote alarm on: send remote alarm while frame alignment lost
// R4 - auto remote alarm on: stop remote alarm once basic alignment regained
// R5 - crc4 mode with auto resync: restart double-frame search after 8 ms
// R6 - crc resync option: new search when over 914 crc errors in one second
// R7 - interworking mode: stay in double framing after 400 ms without multiframe
// R8 - interworking mode: flag an event when the 400 ms search expires
// R9 - extended interworking: after 400 ms raise remote alarm, keep searching multiframe
// R10 - extended interworking: no full resync at each 8 ms interval
// R11 - host sets all three hdlc mode registers to 88 hex
// R12 - channel 1 control 18 hex enables signaling, continuous flags; others 08
// R13 - unmasked hdlc message end, pool full, pool ready events interrupt
// R14 - slot 16 in both slot maps carries hdlc data
// R15 - even/odd select 00 uses both frame parities for hdlc
// R16 - bit mask ff hex uses all eight slot bits
// R17 - channels 2 and 3 use the slots held in their select registers
// R18 - cas enabled and slot option clear: transmit the sixteen signaling registers
// R19 - unmasked cas change event interrupts on any receive signaling change
// R20 - host issues transmitter and receiver soft reset after setup
// R21 - host keeps line standard select at zero for e1
// R22 - events stay flagged until read; masked ones do not interrupt
`timescale 1ns/1ps
module efs_core
  import efs_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // line receive indications (from receive framer pins)
  input  wire efs_line_in_t line_in,
  input  wire logic [7:0]   rx_sig_data,
  input  wire logic [3:0]   rx_sig_idx,
  input  wire logic         rx_sig_valid,
  // overhead to and from transmitter, hdlc maps, receiver resync and search, soft resets, interrupt
  output logic [1:0]        tx_ebits,
  output logic              tx_remote_alarm,
  output logic              tx_cas_en,
  output logic [7:0]        tx_sig_data,
  input  wire logic [3:0]   tx_sig_idx,
  output logic [31:0]       hdlc_slot_map,
  output logic [23:0]       hdlc_bit_mask,
  output logic              rx_resync,
  output logic              mf_search,
  output logic              tx_soft_reset,
  output logic              rx_soft_reset,
  output logic              irq
);

  typedef struct packed {
    efs_line_in_t   li1;
    efs_line_in_t   li2;
    logic [12:0]    sg1;
    logic [12:0]    sg2;
    logic [10:0]    framer;
    logic [10:0]    imask;
    logic [NEV-1:0] events;
    logic [31:0]    hdlc1;
    logic [31:0]    hdlc2;
    logic [31:0]    hdlc3;
    logic [31:0]    slots;
    efs_sync_t      sync;
    logic [15:0]    ms_cnt;
    logic           ms_tick;
    logic [9:0]     mf_ms;
    logic [9:0]     crc_ms;
    logic [9:0]     crc_cnt;
    logic           iw_expired;
    logic [1:0]     smf_stat;
    logic [1:0]     ebits;
    logic           rai;
    logic           resync;
    logic           transmitter_soft_reset;
    logic           receiver_soft_reset;
    logic           pready;
    logic [31:0]    prdata;
    logic           pslverr;
    logic [7:0]     txsig;
    logic           irq;
    logic           cas_en;
    logic           mf_srch;
  } efs_state_t;

  efs_state_t s_q;
  efs_state_t s_d;
  logic [7:0] tx_sig_mem [16];
  logic [7:0] rx_sig_mem [16];
  logic       tx_sig_we;
  logic       rx_sig_we;
  logic       rx_sig_chg;
  logic       rst_n_int;
  logic [1:0] rst_sync_q;

  assign rst_n_int = rst_sync_q[1];

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction : in_range

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  wire logic apb_acc = psel && penable && s_q.pready;
  wire logic apb_wr  = apb_acc && pwrite;
  wire logic apb_rd  = apb_acc && !pwrite;

  assign tx_sig_we  = apb_wr && in_range(paddr, A_TXSIG, A_RXSIG);
  assign rx_sig_we  = s_q.sg2[12];
  assign rx_sig_chg = rx_sig_we && (rx_sig_mem[s_q.sg2[11:8]] != s_q.sg2[7:0]);

  // signaling memories, cleared so a first change compares against zero
  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      for (int i = 0; i < 16; i++) begin
        tx_sig_mem[i] <= '0;
        rx_sig_mem[i] <= '0;
      end
    end else begin
      if (tx_sig_we) begin
        tx_sig_mem[paddr[5:2]] <= pwdata[7:0];
      end
      if (rx_sig_we) begin
        rx_sig_mem[s_q.sg2[11:8]] <= s_q.sg2[7:0];
      end
    end
  end

  always_comb begin
    logic [1:0]     frs;
    logic           ext_iw;
    logic           lost;
    logic           iw_stay;
    logic [NEV-1:0] ev_set;
    logic           read_clr;
    s_d = s_q;
    frs = s_q.framer[B_FRS_LO+1:B_FRS_LO];
    ext_iw = s_q.framer[B_EXT_IW];
    lost = !s_q.li2.frame_ok;
    // plain interworking gives up the multiframe search once expired
    iw_stay = (frs == FRS_IW) && !ext_iw && s_q.iw_expired;
    ev_set = '0;
    read_clr = 1'b0;
    s_d.li1 = line_in;
    s_d.li2 = s_q.li1;
    s_d.sg1 = {rx_sig_valid, rx_sig_idx, rx_sig_data};
    s_d.sg2 = s_q.sg1;
    s_d.resync = 1'b0;
    s_d.transmitter_soft_reset = 1'b0;
    s_d.receiver_soft_reset = 1'b0;
    s_d.txsig = tx_sig_mem[tx_sig_idx];

    // millisecond enable
    s_d.ms_tick = (s_q.ms_cnt == MS_TICK);
    s_d.ms_cnt = s_d.ms_tick ? '0 : s_q.ms_cnt + 16'h0001;

    // sync state
    if (lost) begin
      s_d.sync = SY_ASYNC;
      s_d.mf_ms = '0;
      s_d.iw_expired = 1'b0;
    end else if (s_q.sync == SY_ASYNC) begin
      s_d.sync = SY_BASIC;
      s_d.mf_ms = '0;
    end else if (s_q.sync == SY_BASIC && s_q.li2.mf_found && frs[1] && !iw_stay) begin
      s_d.sync = SY_MULTI;
      s_d.iw_expired = 1'b0;
    end else if (s_q.sync == SY_BASIC && frs[1] && s_q.ms_tick) begin
      s_d.mf_ms = s_q.mf_ms + 10'd1;
      if (frs == FRS_CRC4 && s_q.framer[B_AUTO_RESYN] && !ext_iw &&
          s_q.mf_ms == 10'(T_MF_MS - 1)) begin
        // R5 restart double frame
        // R10 not in extended interworking
        s_d.resync = 1'b1;
        s_d.mf_ms = '0;
      end
      if (frs == FRS_IW && !s_q.iw_expired && s_q.mf_ms == 10'(T_IW_MS - 1)) begin
        // R7 stay double framing
        s_d.iw_expired = 1'b1;
        // R8 400 ms event
        ev_set[E_IW400] = 1'b1;
      end
    end

    // R6 crc error count per second
    if (s_q.li2.crc_err) begin
      s_d.crc_cnt = (s_q.crc_cnt == 10'h3ff) ? s_q.crc_cnt : s_q.crc_cnt + 10'd1;
    end
    if (s_q.ms_tick) begin
      s_d.crc_ms = s_q.crc_ms + 10'd1;
      if (s_q.crc_ms == 10'(T_CRC_MS - 1)) begin
        s_d.crc_ms = '0;
        s_d.crc_cnt = '0;
      end
    end
    if (s_q.framer[B_CRC_RESYN] && s_q.crc_cnt > 10'(CRC_LIMIT)) begin
      s_d.resync = 1'b1;
      s_d.crc_cnt = '0;
      s_d.sync = SY_ASYNC;
    end
    if (s_q.resync) begin
      s_d.sync = SY_ASYNC;
    end

    // e-bit generation
    if (s_q.li2.mf_start) begin
      s_d.smf_stat = {s_q.smf_stat[0], s_q.li2.smf_crc_ok};
    end
    if (s_q.sync == SY_ASYNC) begin
      // R2 polarity in async state
      s_d.ebits = {2{s_q.framer[B_EBIT_POL]}};
    end else if (s_q.framer[B_AUTO_EBIT] && s_q.li2.mf_start) begin
      // R1 insert received crc status
      s_d.ebits = s_q.smf_stat;
    end

    // remote alarm
    if (s_q.framer[B_AUTO_RAI] && lost) begin
      // R3 raise on lost alignment
      s_d.rai = 1'b1;
    end else if (ext_iw && s_q.iw_expired) begin
      // R9 alarm, keep searching
      s_d.rai = 1'b1;
    end else if (s_q.framer[B_AUTO_RAI]) begin
      // R4 clear once realigned
      s_d.rai = 1'b0;
    end else begin
      s_d.rai = 1'b0;
    end

    // R19 cas change event
    ev_set[E_CAS_CHANGE_EVENT] = rx_sig_chg;
    // R13 hdlc events per channel
    ev_set[E_HDLC+8:E_HDLC] = {s_q.li2.hdlc_ev, s_q.li2.receive_message_end, s_q.li2.receive_message_end[0], 
                               s_q.li2.receive_message_end[1], s_q.li2.receive_message_end[0], s_q.li2.hdlc_ev[0]};

    // apb slave
    s_d.pready = 1'b1;
    s_d.pslverr = 1'b0;
    if (psel && !penable) begin
      s_d.pready = 1'b1;
    end
    if (apb_wr) begin
      if (paddr == A_FRAMER) begin
        s_d.framer = pwdata[10:0];
      end else if (paddr == A_IMASK) begin
        s_d.imask = pwdata[10:0];
      end else if (paddr == A_HDLC1) begin
        // R12 channel control
        s_d.hdlc1 = pwdata;
      end else if (paddr == A_HDLC2) begin
        s_d.hdlc2 = pwdata;
      end else if (paddr == A_HDLC3) begin
        s_d.hdlc3 = pwdata;
      end else if (paddr == A_SLOTS) begin
        s_d.slots = pwdata;
      end else if (paddr == A_COMMAND) begin
        s_d.transmitter_soft_reset = pwdata[0];
        s_d.receiver_soft_reset = pwdata[1];
      end
    end
    if (psel && !penable && !pwrite) begin
      s_d.prdata = '0;
      if (paddr == A_FRAMER) begin
        s_d.prdata = 32'(s_q.framer);
      end else if (paddr == A_STATUS) begin
        s_d.prdata = 32'({s_q.rai, s_q.iw_expired, s_q.sync});
      end else if (paddr == A_IMASK) begin
        s_d.prdata = 32'(s_q.imask);
      end else if (paddr == A_EVENTS) begin
        s_d.prdata = 32'(s_q.events);
      end else if (paddr == A_HDLC1) begin
        s_d.prdata = s_q.hdlc1;
      end else if (paddr == A_HDLC2) begin
        s_d.prdata = s_q.hdlc2;
      end else if (paddr == A_HDLC3) begin
        s_d.prdata = s_q.hdlc3;
      end else if (paddr == A_SLOTS) begin
        s_d.prdata = s_q.slots;
      end else if (in_range(paddr, A_TXSIG, A_RXSIG)) begin
        s_d.prdata = 32'(tx_sig_mem[paddr[5:2]]);
      end else if (in_range(paddr, A_RXSIG, A_SIG_END)) begin
        s_d.prdata = 32'(rx_sig_mem[paddr[5:2]]);
      end
    end
    read_clr = apb_rd && (paddr == A_EVENTS);
    // R22 sticky until read, set wins; only bits the host saw are cleared
    s_d.events = (s_q.events & ~(read_clr ? s_q.prdata[NEV-1:0] : '0)) | ev_set;
    s_d.irq = |(s_q.events & ~s_q.imask);
    // R18 cas enable from control bits
    s_d.cas_en = s_q.framer[B_CAS_EN] && !s_q.framer[B_SIG_OPT];
    s_d.mf_srch = (s_d.sync == SY_BASIC) && frs[1] && !iw_stay;
  end

  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_q        <= '0;
      s_q.framer <= FRAMER_RST;
      s_q.imask  <= IMASK_RST;
      s_q.sync   <= SY_ASYNC;
    end else begin
      s_q <= s_d;
    end
  end

  // R14 slot 16 from both maps
  // R15 even and odd frames
  // R16 bit masks
  // R17 channel 2 and 3 slots
  assign hdlc_slot_map = s_q.slots;
  assign hdlc_bit_mask = {s_q.hdlc3[15:8], s_q.hdlc2[15:8], s_q.hdlc1[15:8]};
  // R18 cas from transmit registers
  assign tx_cas_en       = s_q.cas_en;
  assign tx_sig_data     = s_q.txsig;
  assign tx_ebits        = s_q.ebits;
  assign tx_remote_alarm = s_q.rai;
  assign rx_resync       = s_q.resync;
  assign mf_search       = s_q.mf_srch;
  assign tx_soft_reset   = s_q.transmitter_soft_reset;
  assign rx_soft_reset   = s_q.receiver_soft_reset;
  assign irq             = s_q.irq;
  assign pready          = s_q.pready;
  assign prdata          = s_q.prdata;
  assign pslverr         = s_q.pslverr;

endmodule : efs_core

// file: test/efs_core_sva.sv
// port assertions for the framer sync and overhead block
`timescale 1ns/1ps
module efs_core_sva
  import efs_pkg::*;
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         rst_b,
  // apb slave
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // line side and overhead
  input wire efs_line_in_t line_in,
  input wire logic [3:0]   tx_sig_idx,
  input wire logic [7:0]   tx_sig_data,
  input wire logic [1:0]   tx_ebits,
  input wire logic         tx_remote_alarm,
  input wire logic         tx_cas_en,
  input wire logic         tx_soft_reset,
  input wire logic         rx_soft_reset,
  input wire logic         irq
);
  logic        wr;
  logic [10:0] fr_q;
  logic [10:0] msk_q;
  logic [7:0]  sig_q [16];
  logic [7:0]  sig_exp_q;

  assign wr = psel && penable && pready && pwrite;

  // shadow copies of host writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fr_q <= FRAMER_RST;
      msk_q <= IMASK_RST;
      sig_exp_q <= 8'h00;
      for (int i = 0; i < 16; i++) sig_q[i] <= 8'h00;
    end else begin
      sig_exp_q <= sig_q[tx_sig_idx];
      if (wr && paddr == A_FRAMER) fr_q <= pwdata[10:0];
      if (wr && paddr == A_IMASK) msk_q <= pwdata[10:0];
      if (wr && paddr[7:6] == 2'b01) sig_q[paddr[5:2]] <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_tx_cmd;
    wr && paddr == A_COMMAND && pwdata[0];
  endsequence
  sequence s_rx_cmd;
    wr && paddr == A_COMMAND && pwdata[1];
  endsequence
  sequence s_lost;
    (fr_q[B_AUTO_RAI] && !line_in.frame_ok) [*6];
  endsequence
  sequence s_aligned;
    (fr_q[B_AUTO_RAI] && !fr_q[B_EXT_IW] && line_in.frame_ok) [*6];
  endsequence

  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("apb access phase not ready");
  no_error_a: assert property (psel |-> !pslverr)
    else $error("apb error response seen");
  ebit_async_a: assert property (
    (!line_in.frame_ok && $stable(fr_q)) [*6] |-> tx_ebits == {2{fr_q[B_EBIT_POL]}})
    else $error("async e-bits differ from polarity");
  rai_on_a: assert property (s_lost |-> tx_remote_alarm)
    else $error("remote alarm missing on lost alignment");
  rai_off_a: assert property (s_aligned |-> !tx_remote_alarm)
    else $error("remote alarm kept after alignment");
  irq_masked_a: assert property ((msk_q == IMASK_RST) [*3] |-> !irq)
    else $error("interrupt with all sources masked");
  cas_en_a: assert property (
    $stable(fr_q) [*3] |-> tx_cas_en == (fr_q[B_CAS_EN] && !fr_q[B_SIG_OPT]))
    else $error("cas enable wrong");
  sig_data_a: assert property (tx_cas_en |-> tx_sig_data == sig_exp_q)
    else $error("transmit signaling byte wrong");
  tx_reset_a: assert property (s_tx_cmd |-> ##[1:3] tx_soft_reset)
    else $error("transmitter reset pulse missing");
  rx_reset_a: assert property (s_rx_cmd |-> ##[1:3] rx_soft_reset)
    else $error("receiver reset pulse missing");
endmodule : efs_core_sva

bind efs_core efs_core_sva chk_i (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
  .tx_sig_idx(tx_sig_idx), .tx_sig_data(tx_sig_data), .tx_ebits(tx_ebits),
  .tx_remote_alarm(tx_remote_alarm), .tx_cas_en(tx_cas_en), .tx_soft_reset(tx_soft_reset),
  .rx_soft_reset(rx_soft_reset), .irq(irq)
);

// file: test/efs_line_model.sv
// remote line terminal model driving receive indications
`timescale 1ns/1ps
module efs_line_model
  import efs_pkg::*;
(
  // clock
  input  wire logic    mclk,
  // receive indications
  output efs_line_in_t line_in,
  output logic [7:0]   rx_sig_data,
  output logic [3:0]   rx_sig_idx,
  output logic         rx_sig_valid
);
  initial begin
    line_in = '0;
    rx_sig_data = 8'h00;
    rx_sig_idx = 4'h0;
    rx_sig_valid = 1'b0;
  end
  task automatic set_align(input logic ok);
    @(posedge mclk);
    line_in.frame_ok <= ok;
  endtask : set_align
  task automatic set_mf(input logic f);
    @(posedge mclk);
    line_in.mf_found <= f;
  endtask : set_mf
  // crc errors flagged on n consecutive cycles
  task automatic crc_errors(input int n);
    @(posedge mclk);
    line_in.crc_err <= 1'b1;
    repeat (n) @(posedge mclk);
    line_in.crc_err <= 1'b0;
  endtask : crc_errors
  task automatic hdlc_burst(input logic [2:0] ev);
    @(posedge mclk);
    line_in.hdlc_ev <= ev;
    @(posedge mclk);
    line_in.hdlc_ev <= 3'h0;
  endtask : hdlc_burst
  // released data shows the inverse so stale values are never reused
  task automatic sig_change(input logic [3:0] i, input logic [7:0] d);
    @(posedge mclk);
    rx_sig_idx <= i;
    rx_sig_data <= d;
    rx_sig_valid <= 1'b1;
    @(posedge mclk);
    rx_sig_valid <= 1'b0;
    rx_sig_data <= ~d;
  endtask : sig_change
endmodule : efs_line_model

// file: test/efs_core_bench.sv
// self-checking bench for the framer sync and overhead block
`timescale 1ns/1ps
module efs_core_bench
  import efs_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [3:0]   tx_sig_idx = 4'h0;
  logic         pready, irq, tx_remote_alarm, tx_cas_en, tx_soft_reset, rx_soft_reset;
  logic [31:0]  prdata, hdlc_slot_map, v;
  logic [1:0]   tx_ebits;
  logic [7:0]   tx_sig_data, rx_sig_data;
  logic [23:0]  hdlc_bit_mask;
  logic [3:0]   rx_sig_idx;
  logic         rx_sig_valid;
  logic         rx_resync, mf_search;
  efs_line_in_t line_in;
  int           err_count = 0;
  int           n_tests = 0;

  always #12.5 mclk = ~mclk;

  efs_core dut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(),
    .line_in(line_in), .rx_sig_data(rx_sig_data), .rx_sig_idx(rx_sig_idx),
    .rx_sig_valid(rx_sig_valid), .tx_ebits(tx_ebits), .tx_remote_alarm(tx_remote_alarm),
    .tx_cas_en(tx_cas_en), .tx_sig_data(tx_sig_data), .tx_sig_idx(tx_sig_idx),
    .hdlc_slot_map(hdlc_slot_map), .hdlc_bit_mask(hdlc_bit_mask), .rx_resync(rx_resync),
    .mf_search(mf_search), .tx_soft_reset(tx_soft_reset),
    .rx_soft_reset(rx_soft_reset), .irq(irq));
  efs_line_model lm (.mclk(mclk), .line_in(line_in), .rx_sig_data(rx_sig_data),
    .rx_sig_idx(rx_sig_idx), .rx_sig_valid(rx_sig_valid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) chk(32'h0, 32'h1);
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(v, e);
  endtask : rd

  task automatic t_regs;
    rd(A_FRAMER, {21'h0, FRAMER_RST});
    rd(A_IMASK, {21'h0, IMASK_RST});
    apb(1'b1, 8'h24, 32'ha5);
    rd(8'h24, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic t_ebit_rai;
    lm.set_align(1'b0);
    apb(1'b1, A_FRAMER, 32'h7);
    wt(8);
    chk({30'h0, tx_ebits}, 32'h3);
    chk({31'h0, tx_remote_alarm}, 32'h1);
    lm.set_align(1'b1);
    wt(8);
    chk({31'h0, tx_remote_alarm}, 32'h0);
    lm.set_align(1'b0);
    apb(1'b1, A_FRAMER, 32'h5);
    wt(8);
    chk({30'h0, tx_ebits}, 32'h0);
    chk({31'h0, tx_remote_alarm}, 32'h1);
    $display("e-bit and alarm test done");
  endtask : t_ebit_rai
  task automatic t_hdlc;
    apb(1'b1, A_HDLC1, 32'h0088_ff18);
    apb(1'b1, A_HDLC2, 32'h0088_ff08);
    apb(1'b1, A_HDLC3, 32'h0088_ff08);
    apb(1'b1, A_SLOTS, 32'h0001_0006);
    wt(3);
    chk({8'h0, hdlc_bit_mask}, 32'h00ff_ffff);
    chk(hdlc_slot_map, 32'h0001_0006);
    rd(A_HDLC1, 32'h0088_ff18);
    rd(A_HDLC3, 32'h0088_ff08);
    $display("hdlc test done");
  endtask : t_hdlc
  task automatic t_irq;
    apb(1'b1, A_IMASK, 32'h0);
    lm.hdlc_burst(3'h7);
    wt(6);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, A_EVENTS, 32'h0);
    chk({31'h0, |v[10:2]}, 32'h1);
    rd(A_EVENTS, 32'h0);
    wt(4);
    chk({31'h0, irq}, 32'h0);
    lm.sig_change(4'h3, 8'h5a);
    wt(6);
    chk({31'h0, irq}, 32'h1);
    rd(A_EVENTS, 32'h2);
    rd(A_RXSIG + 8'h0c, 32'h5a);
    apb(1'b1, A_IMASK, 32'h7ff);
    lm.sig_change(4'h3, 8'h3c);
    wt(6);
    chk({31'h0, irq}, 32'h0);
    rd(A_EVENTS, 32'h2);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_cas_cmd;
    int ntx = 0;
    int nrx = 0;
    apb(1'b1, A_TXSIG + 8'h14, 32'ha5);
    apb(1'b1, A_FRAMER, 32'h100);
    @(posedge mclk);
    tx_sig_idx <= 4'h5;
    wt(3);
    chk({31'h0, tx_cas_en}, 32'h1);
    chk({24'h0, tx_sig_data}, 32'ha5);
    apb(1'b1, A_FRAMER, 32'h300);
    wt(3);
    chk({31'h0, tx_cas_en}, 32'h0);
    apb(1'b1, A_COMMAND, 32'h3);
    #1;
    repeat (6) begin
      ntx += int'(tx_soft_reset === 1'b1);
      nrx += int'(rx_soft_reset === 1'b1);
      wt(1);
    end
    chk(32'(ntx), 32'h1);
    chk(32'(nrx), 32'h1);
    $display("cas and command test done");
  endtask : t_cas_cmd
  task automatic t_sync;
    int nrs = 0;
    lm.set_align(1'b1);
    apb(1'b1, A_FRAMER, 32'h50);
    wt(6);
    chk({31'h0, mf_search}, 32'h1);
    lm.set_mf(1'b1);
    wt(6);
    chk({31'h0, mf_search}, 32'h0);
    lm.set_mf(1'b0);
    lm.crc_errors(CRC_LIMIT);
    wt(6);
    rd(A_STATUS, 32'(SY_MULTI));
    lm.crc_errors(1);
    #1;
    repeat (8) begin
      nrs += int'(rx_resync === 1'b1);
      wt(1);
    end
    chk(32'(nrs), 32'h1);
    wt(4);
    chk({31'h0, mf_search}, 32'h1);
    $display("sync test done");
  endtask : t_sync

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_ebit_rai();
    t_hdlc();
    t_irq();
    t_cas_cmd();
    t_sync();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end
endmodule : efs_core_bench
